// ==== src/dip_fifo.sv ====
// two-channel sample fifo with loadable write and clearable read pointer
`timescale 1ns/1ps
module dip_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input  logic       clk_i,
  input  logic       rst_n_i,
  input  logic       ce_i,
  // fifo port
  dip_fifo_if.store  f
);
  import dip_pkg::*;

  // depth must be a power of two: pointers wrap by overflow
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW:0]   count;
  logic [PW:0]   next_count;
  logic [PW-1:0] next_wptr;
  logic [PW-1:0] next_rptr;
  logic          do_push;
  logic          do_pop;

  assign f.push_ready = (count != (PW+1)'(DEPTH));
  assign f.pop_valid  = (count != '0);

  always_comb begin
    do_push   = f.push && f.push_ready;
    do_pop    = f.pop && f.pop_valid;
    next_wptr = f.wptr;
    next_rptr = f.rptr;
    if (f.wptr_load) begin
      next_wptr = f.wptr_val;
    end else if (do_push) begin
      next_wptr = f.wptr + 1'b1;
    end
    if (f.rptr_clear) begin
      next_rptr = '0;
    end else if (do_pop) begin
      next_rptr = f.rptr + 1'b1;
    end
    if (f.wptr_load || f.rptr_clear) begin
      next_count = {1'b0, next_wptr - next_rptr};
    end else begin
      next_count = count + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f.wptr <= '0;
      f.rptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      f.wptr <= next_wptr;
      f.rptr <= next_rptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem[f.wptr] <= f.push_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f.pop_data <= '0;
    end else if (ce_i && do_pop) begin
      f.pop_data <= mem[f.rptr];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_count_bound: assert property (count <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_wptr_step: assert property (ce_i && do_push && !f.wptr_load |=>
    f.wptr == $past(f.wptr) + 1'b1)
    else $error("write pointer did not advance");
  a_rptr_step: assert property (ce_i && do_pop && !f.rptr_clear |=>
    f.rptr == $past(f.rptr) + 1'b1)
    else $error("read pointer did not advance");
endmodule

// ==== src/dip_fifo_if.sv ====
// signals between the input port control and the pointer fifo
`timescale 1ns/1ps
interface dip_fifo_if #(parameter int W = 32, parameter int PW = 3);
  logic          push;
  logic [W-1:0]  push_data;
  logic          push_ready;
  logic          pop;
  logic          pop_valid;
  logic [W-1:0]  pop_data;
  logic          wptr_load;
  logic [PW-1:0] wptr_val;
  logic          rptr_clear;
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;

  modport ctrl (output push, push_data, pop, wptr_load, wptr_val, rptr_clear,
                input  push_ready, pop_valid, pop_data, wptr, rptr);
  modport store (input  push, push_data, pop, wptr_load, wptr_val, rptr_clear,
                 output push_ready, pop_valid, pop_data, wptr, rptr);
endinterface

// ==== src/dip_frame_hold.sv ====
// counts consecutive captures with frame high and flags the full-pair hold
`timescale 1ns/1ps
module dip_frame_hold #(
  parameter int CW = 3
) (
  // clock, reset, enable
  input  logic          clk_i,
  input  logic          rst_n_i,
  input  logic          ce_i,
  // capture side
  input  logic          strike_i,
  input  logic          frame_i,
  input  logic [CW-1:0] need_i,
  // result
  output logic          hit_o
);
  import dip_pkg::*;

  logic [CW-1:0] run;

  // fires once per high run; the count saturates so it cannot refire
  assign hit_o = strike_i && frame_i && (run == need_i - 1'b1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= '0;
    end else if (ce_i && strike_i) begin
      if (!frame_i) begin
        run <= '0;
      end else if (run != '1) begin
        run <= run + 1'b1;
      end
    end
  end
endmodule

// ==== src/dip_input_port.sv ====
// parallel input data port, sample formatting and fifo pointer control
`timescale 1ns/1ps
module dip_input_port (
  // clock, reset, enable
  input  logic                          clk_i,
  input  logic                          rst_n_i,
  input  logic                          ce_i,
  // parallel data port
  input  logic [dip_pkg::BUS_W-1:0]     data_bus_i,
  input  logic                          frame_i,
  input  logic                          data_qualify_clock_i,
  // static configuration
  input  dip_pkg::dip_port_mode_t       port_mode_i,
  input  dip_pkg::dip_res_t             resolution_i,
  // converter side
  input  logic                          rate_tick_i,
  input  logic                          sync_pos_i,
  input  logic                          sync_neg_i,
  // serial port registers
  input  logic [7:0]                    reg_addr_i,
  input  logic                          reg_wr_i,
  input  logic                          reg_rd_i,
  input  logic [7:0]                    reg_wdata_i,
  output logic [7:0]                    reg_rdata_o,
  // datapath output
  output logic [dip_pkg::SAMPLE_W-1:0]  i_sample_o,
  output logic [dip_pkg::SAMPLE_W-1:0]  q_sample_o,
  output logic                          sample_valid_o,
  output logic                          in_ready_o,
  output logic                          fifo_warn_o
);
  import dip_pkg::*;

  localparam int PAIR_W = 2 * SAMPLE_W;

  // =====================================================
  // capture strike
  logic dqc_d;
  logic strike;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dqc_d <= 1'b0;
    end else if (ce_i) begin
      dqc_d <= data_qualify_clock_i;
    end
  end

  // falling edge of the qualify clock is the sampling point
  assign strike = dqc_d && !data_qualify_clock_i;

  // =====================================================
  // resolution mask
  logic [SAMPLE_W-1:0] res_mask;

  always_comb begin
    unique case (resolution_i)
      DIP_RES_14: res_mask = MASK_14;
      DIP_RES_12: res_mask = MASK_12;
      default:    res_mask = MASK_16;
    endcase
  end

  // =====================================================
  // sample assembly
  logic [SAMPLE_W-1:0] word_in;
  logic [7:0]          byte_in;
  logic [SAMPLE_W-1:0] i_hold;
  logic [SAMPLE_W-1:0] next_i_hold;
  logic [7:0]          q_hi;
  logic [7:0]          next_q_hi;
  logic                byte_phase;
  logic                next_byte_phase;
  logic                cap_frame;
  logic                push_q;
  logic                next_push;
  logic [PAIR_W-1:0]   push_pair;
  logic [PAIR_W-1:0]   next_pair;
  logic                first_byte;

  assign word_in    = data_bus_i[SAMPLE_W-1:0];
  assign byte_in    = data_bus_i[7:0];
  // a frame edge restarts the byte order, so a slip heals on the next sample
  assign first_byte = (frame_i != cap_frame) || !byte_phase;

  always_comb begin
    next_push       = 1'b0;
    next_pair       = push_pair;
    next_i_hold     = i_hold;
    next_q_hi       = q_hi;
    next_byte_phase = byte_phase;
    if (strike) begin
      unique case (port_mode_i)
        DIP_DUAL_WORD: begin
          next_push = 1'b1;
          next_pair = data_bus_i;
        end
        DIP_WORD: begin
          if (frame_i) begin
            next_i_hold = word_in & res_mask;
          end else begin
            next_push = 1'b1;
            next_pair = {i_hold, word_in & res_mask};
          end
        end
        DIP_BYTE: begin
          if (first_byte) begin
            next_byte_phase = 1'b1;
            if (frame_i) begin
              next_i_hold = {byte_in, 8'h00};
            end else begin
              next_q_hi = byte_in;
            end
          end else begin
            next_byte_phase = 1'b0;
            if (frame_i) begin
              next_i_hold = {i_hold[15:8], byte_in} & res_mask;
            end else begin
              next_push = 1'b1;
              next_pair = {i_hold, {q_hi, byte_in} & res_mask};
            end
          end
        end
        default: begin
          next_push = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i_hold     <= '0;
      q_hi       <= '0;
      byte_phase <= 1'b0;
      cap_frame  <= 1'b0;
      push_q     <= 1'b0;
      push_pair  <= '0;
    end else if (ce_i) begin
      i_hold     <= next_i_hold;
      q_hi       <= next_q_hi;
      byte_phase <= next_byte_phase;
      push_q     <= next_push;
      push_pair  <= next_pair;
      if (strike) begin
        cap_frame <= frame_i;
      end
    end
  end

  // =====================================================
  // registers
  logic [7:0] sync_mode;
  logic [2:0] phase_off;
  logic       init_req;
  logic       init_ack;
  logic [7:0] status_word;
  logic [6:0] therm;
  logic [2:0] level;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_mode <= SYNC_MODE_RESET;
      phase_off <= PHASE_OFFSET_RESET;
      init_req  <= 1'b0;
    end else if (ce_i && reg_wr_i) begin
      unique case (reg_addr_i)
        SYNC_MODE_ADDR:    sync_mode <= reg_wdata_i;
        PHASE_OFFSET_ADDR: phase_off <= reg_wdata_i[2:0];
        INIT_STATUS_ADDR:  init_req  <= reg_wdata_i[INIT_REQ_BIT];
        default:           sync_mode <= sync_mode;
      endcase
    end
  end

  always_comb begin
    status_word               = 8'h00;
    status_word[INIT_REQ_BIT] = init_req;
    status_word[INIT_ACK_BIT] = init_ack;
    status_word[WARN_BIT]     = fifo_warn_o;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      unique case (reg_addr_i)
        SYNC_MODE_ADDR:    reg_rdata_o <= sync_mode;
        PHASE_OFFSET_ADDR: reg_rdata_o <= {5'h00, phase_off};
        INIT_STATUS_ADDR:  reg_rdata_o <= status_word;
        FIFO_LEVEL_ADDR:   reg_rdata_o <= {1'b0, therm};
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // =====================================================
  // fifo
  dip_fifo_if #(.W(PAIR_W), .PW(PTR_W)) fif ();

  dip_fifo #(
    .W     (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .f       (fif.store)
  );

  logic pop;
  logic out_valid;

  // a tick against an empty fifo is skipped rather than reading stale data
  assign pop            = rate_tick_i && fif.pop_valid;
  assign fif.push       = push_q;
  assign fif.push_data  = push_pair;
  assign fif.pop        = pop;
  assign in_ready_o     = fif.push_ready;
  assign i_sample_o     = fif.pop_data[PAIR_W-1:SAMPLE_W];
  assign q_sample_o     = fif.pop_data[SAMPLE_W-1:0];
  assign sample_valid_o = out_valid;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid <= 1'b0;
    end else if (ce_i) begin
      out_valid <= pop;
    end
  end

  // =====================================================
  // level and warning
  assign level = fif.wptr - fif.rptr;

  always_comb begin
    for (int k = 0; k < 7; k++) begin
      therm[k] = (level > 3'(k));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_warn_o <= 1'b0;
    end else if (ce_i) begin
      fifo_warn_o <= (level == LEVEL_LOW) || (level == LEVEL_HIGH);
    end
  end

  // =====================================================
  // pointer resets
  logic       fifo_rate;
  logic       frame_hit;
  logic [2:0] hold_need;
  logic       sync_sel;
  logic       sync_d;
  logic       zero_evt;
  logic       abs_load;
  logic       req_d;
  logic       ser_pend;
  logic       frm_pend;

  assign fifo_rate = sync_mode[SYNC_EN_BIT] && !sync_mode[SYNC_RATE_BIT];

  always_comb begin
    unique case (port_mode_i)
      DIP_DUAL_WORD: hold_need = HOLD_DUAL;
      DIP_WORD:      hold_need = HOLD_WORD;
      default:       hold_need = HOLD_BYTE;
    endcase
  end

  dip_frame_hold #(.CW(3)) u_hold (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .strike_i (strike),
    .frame_i  (frame_i),
    .need_i   (hold_need),
    .hit_o    (frame_hit)
  );

  assign sync_sel       = sync_mode[SYNC_EDGE_BIT] ? sync_neg_i : sync_pos_i;
  assign fif.rptr_clear = fifo_rate && sync_sel && !sync_d;
  // wrap from seven or a sync clear both count as the read pointer reaching zero
  assign zero_evt       = (pop && fif.rptr == 3'h7) || fif.rptr_clear;
  assign abs_load       = frame_hit && fifo_rate;
  assign fif.wptr_load  = abs_load || ((ser_pend || frm_pend) && zero_evt);
  assign fif.wptr_val   = phase_off;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_d   <= 1'b0;
      req_d    <= 1'b0;
      ser_pend <= 1'b0;
      frm_pend <= 1'b0;
      init_ack <= 1'b0;
    end else if (ce_i) begin
      sync_d <= sync_sel;
      req_d  <= init_req;
      // a new arm wins over the release in the same cycle
      if (init_req && !req_d) begin
        ser_pend <= 1'b1;
      end else if (zero_evt) begin
        ser_pend <= 1'b0;
      end
      if (frame_hit && !fifo_rate) begin
        frm_pend <= 1'b1;
      end else if (zero_evt) begin
        frm_pend <= 1'b0;
      end
      if (ser_pend && zero_evt && init_req) begin
        init_ack <= 1'b1;
      end else if (!init_req) begin
        init_ack <= 1'b0;
      end
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_dual_split: assert property (ce_i && strike && port_mode_i == DIP_DUAL_WORD
    |=> push_q && push_pair == $past(data_bus_i))
    else $error("dual word pair not taken from both bus halves");
  a_word_steer: assert property (ce_i && strike && port_mode_i == DIP_WORD && frame_i
    |=> !push_q && i_hold == ($past(word_in) & $past(res_mask)))
    else $error("frame high word not held for the I channel");
  a_word_mask: assert property (push_q && port_mode_i == DIP_WORD
    |-> (push_pair[SAMPLE_W-1:0] & ~res_mask) == 16'h0000)
    else $error("insignificant word bits not dropped");
  a_byte_mask: assert property (push_q && port_mode_i == DIP_BYTE
    |-> (push_pair[SAMPLE_W-1:0] & ~res_mask) == 16'h0000)
    else $error("insignificant byte bits not dropped");
  a_abs_load: assert property (ce_i && abs_load
    |=> fif.wptr == $past(phase_off))
    else $error("absolute reset did not force the write pointer");
  a_rel_load: assert property (ce_i && (ser_pend || frm_pend) && zero_evt
    |=> fif.wptr == $past(phase_off) && fif.rptr == 3'h0)
    else $error("relative reset did not load the phase offset at read zero");
  a_ack_drop: assert property (ce_i && !init_req |=> !init_ack)
    else $error("acknowledge held after request removed");
  a_sync_clear: assert property (ce_i && fif.rptr_clear |=> fif.rptr == 3'h0)
    else $error("sync did not clear the read pointer");
  a_warn_level: assert property (ce_i |=>
    fifo_warn_o == ($past(level) == LEVEL_LOW || $past(level) == LEVEL_HIGH))
    else $error("warning flag does not follow level");
endmodule

// ==== src/dip_pkg.sv ====
// constants, types and register map of the dac input port and fifo
// How it works
// - word and byte modes: frame high steers to I, frame low to Q
// - word mode drops two LSBs on 14-bit, four on 12-bit parts
// - byte mode drops unused low bits of the second byte on narrow parts
// - bus and frame sampled on qualify clock falling edge, held stable by source
// - fifo holds two 16-bit channels, eight entries deep
// - formatted pair written at write pointer, then write pointer advances
// - one entry read per data-rate tick, read pointer advances
// - equal pointers mean empty or overflow; system keeps them apart
// - serial reset always relative; frame reset relative unless fifo rate mode
// - fifo rate mode frame strobe forces write pointer absolutely
// - after request, at next read pointer zero, write pointer takes phase offset
// - acknowledge set while request held, dropped after request removed
// - data rate mode frame strobe loads start level at next read zero
// - fifo rate mode clears read pointer from selected sync edge
// - fifo rate mode loads phase offset right after frame hold interval
// - sync mode bit at zero picks fifo rate when enable bit set; at one, or enable clear, data rate
// - dual-word mode: I from upper bus half, Q from lower
// - level reads as 7-bit thermometer of write minus read pointer
// - warning flag raised when level is one or seven
package dip_pkg;

  // =====================================================
  // sizes
  localparam int BUS_W      = 32;
  localparam int SAMPLE_W   = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W      = 3;

  // =====================================================
  // register offsets
  localparam logic [7:0] SYNC_MODE_ADDR    = 8'h10;
  localparam logic [7:0] PHASE_OFFSET_ADDR = 8'h17;
  localparam logic [7:0] INIT_STATUS_ADDR  = 8'h18;
  localparam logic [7:0] FIFO_LEVEL_ADDR   = 8'h19;

  // =====================================================
  // field positions
  localparam int SYNC_EDGE_BIT = 3;
  localparam int SYNC_RATE_BIT = 6;
  localparam int SYNC_EN_BIT   = 7;
  localparam int INIT_REQ_BIT  = 1;
  localparam int INIT_ACK_BIT  = 2;
  localparam int WARN_BIT      = 7;

  // =====================================================
  // reset values
  localparam logic [7:0] SYNC_MODE_RESET    = 8'h00;
  localparam logic [2:0] PHASE_OFFSET_RESET = 3'h4;

  // =====================================================
  // levels, frame hold lengths, resolution masks
  localparam logic [2:0]  LEVEL_LOW  = 3'h1;
  localparam logic [2:0]  LEVEL_HIGH = 3'h7;
  localparam logic [2:0]  HOLD_DUAL  = 3'h1;
  localparam logic [2:0]  HOLD_WORD  = 3'h2;
  localparam logic [2:0]  HOLD_BYTE  = 3'h4;
  localparam logic [15:0] MASK_16    = 16'hFFFF;
  localparam logic [15:0] MASK_14    = 16'hFFFC;
  localparam logic [15:0] MASK_12    = 16'hFFF0;

  typedef enum logic [1:0] {DIP_DUAL_WORD, DIP_WORD, DIP_BYTE} dip_port_mode_t;
  typedef enum logic [1:0] {DIP_RES_16, DIP_RES_14, DIP_RES_12} dip_res_t;

endpackage

// ==== verif/dip_src_model.sv ====
// behavioural parallel data source for the dac input port
`timescale 1ns/1ps
module dip_src_model (
  // clock
  input  wire logic   clk_i,
  // parallel data port
  output logic [31:0] data_bus_o,
  output logic        frame_o,
  output logic        dqc_o
);
  import dip_pkg::*;

  initial begin
    data_bus_o = 32'h0000_0000;
    frame_o    = 1'b0;
    dqc_o      = 1'b0;
  end

  // =====================================================
  // one transfer, captured where the qualify clock falls
  task automatic xfer(input logic [31:0] d, input logic f);
    @(posedge clk_i);
    data_bus_o <= d;
    frame_o    <= f;
    dqc_o      <= 1'b1;
    @(posedge clk_i);
    dqc_o      <= 1'b0;
    @(posedge clk_i);
    // bus no longer valid once the capture edge is past
    data_bus_o <= ~d;
  endtask

  // =====================================================
  // one i/q pair in the chosen port mode
  task automatic pair(input dip_port_mode_t m, input logic [15:0] i, input logic [15:0] q);
    case (m)
      DIP_DUAL_WORD: xfer({i, q}, 1'b0);
      DIP_WORD: begin
        xfer({~i, i}, 1'b1);
        xfer({~q, q}, 1'b0);
      end
      default: begin
        xfer({24'hA5_A5A5, i[15:8]}, 1'b1);
        xfer({24'h5A_5A5A, i[7:0]}, 1'b1);
        xfer({24'hA5_A5A5, q[15:8]}, 1'b0);
        xfer({24'h5A_5A5A, q[7:0]}, 1'b0);
      end
    endcase
  endtask

  // frame held high over n captures asks for a pointer reset;
  // one frame-low capture first so the high run starts afresh
  // (in word mode that capture pushes one pair)
  task automatic strobe(input int n);
    xfer(32'h0000_0000, 1'b0);
    repeat (n) xfer(32'h0000_0000, 1'b1);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the dac input port and its fifo
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import dip_pkg::*;
  typedef struct packed {
    dip_port_mode_t m;
    dip_res_t       r;
    logic [15:0]    i, q, ei, eq;
  } dip_row_t;

  logic           clk_i, rst_n_i, ce_i, rate_tick_i, sync_pos_i, sync_neg_i;
  logic           reg_wr_i, reg_rd_i, frame, dqc;
  logic           sample_valid_o, in_ready_o, fifo_warn_o;
  logic [7:0]     reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [31:0]    bus;
  logic [15:0]    i_sample_o, q_sample_o;
  dip_port_mode_t port_mode_i;
  dip_res_t       resolution_i;
  int             mismatches = 0;
  int             tests_run = 0;

  // =====================================================
  // ordinary cases: mode, width, sent pair, expected pair
  dip_row_t rows [8] = '{
    '{DIP_DUAL_WORD, DIP_RES_16, 16'h1234, 16'h5678, 16'h1234, 16'h5678},
    '{DIP_DUAL_WORD, DIP_RES_12, 16'hABCD, 16'h0123, 16'hABCD, 16'h0123},
    '{DIP_WORD, DIP_RES_16, 16'hBEEF, 16'hCAFE, 16'hBEEF, 16'hCAFE},
    '{DIP_WORD, DIP_RES_14, 16'h1237, 16'hFFFF, 16'h1234, 16'hFFFC},
    '{DIP_WORD, DIP_RES_12, 16'h89AB, 16'h765F, 16'h89A0, 16'h7650},
    '{DIP_BYTE, DIP_RES_16, 16'h4321, 16'h8765, 16'h4321, 16'h8765},
    '{DIP_BYTE, DIP_RES_14, 16'h00FF, 16'hF00F, 16'h00FC, 16'hF00C},
    '{DIP_BYTE, DIP_RES_12, 16'h5A5A, 16'hA5A5, 16'h5A50, 16'hA5A0}
  };

  dip_src_model src (.clk_i(clk_i), .data_bus_o(bus), .frame_o(frame), .dqc_o(dqc));

  dip_input_port dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .data_bus_i(bus), .frame_i(frame), .data_qualify_clock_i(dqc),
    .port_mode_i(port_mode_i), .resolution_i(resolution_i),
    .rate_tick_i(rate_tick_i), .sync_pos_i(sync_pos_i), .sync_neg_i(sync_neg_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .i_sample_o(i_sample_o), .q_sample_o(q_sample_o),
    .sample_valid_o(sample_valid_o), .in_ready_o(in_ready_o), .fifo_warn_o(fifo_warn_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // =====================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(reg_rdata_o, e)
  endtask

  task automatic tick;
    @(posedge clk_i);
    rate_tick_i <= 1'b1;
    @(posedge clk_i);
    rate_tick_i <= 1'b0;
    #1;
  endtask

  task automatic pop_chk(input logic [15:0] ei, input logic [15:0] eq);
    tick;
    `CHK(sample_valid_o, 1'b1)
    `CHK(i_sample_o, ei)
    `CHK(q_sample_o, eq)
  endtask

  // push one dual pair then pop one entry; moves both pointers by one
  task automatic spin(input int n);
    repeat (n) begin
      src.pair(DIP_DUAL_WORD, 16'h0000, 16'h0000);
      repeat (3) @(posedge clk_i);
      tick;
      `CHK(sample_valid_o, 1'b1)
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // run needs a few hundred cycles; generous margin
  initial begin
    #(25 * 30000);
    mismatches++;
    close_out;
  end

  // =====================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    rate_tick_i = 1'b0;
    sync_pos_i = 1'b0;
    sync_neg_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    port_mode_i = DIP_DUAL_WORD;
    resolution_i = DIP_RES_16;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(in_ready_o, 1'b1)
    `CHK(sample_valid_o, 1'b0)
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[k]) begin
      @(posedge clk_i);
      port_mode_i  <= rows[k].m;
      resolution_i <= rows[k].r;
      src.pair(rows[k].m, rows[k].i, rows[k].q);
      repeat (3) @(posedge clk_i);
      pop_chk(rows[k].ei, rows[k].eq);
    end
    rd(8'h10, 8'h00);
    rd(8'h17, 8'h04);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h5A);
    wr(8'h10, 8'h00);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h07);
    // fill until refused, then drain until empty
    @(posedge clk_i);
    port_mode_i  <= DIP_DUAL_WORD;
    resolution_i <= DIP_RES_16;
    for (int k = 0; k < 9; k++) begin
      src.pair(DIP_DUAL_WORD, 16'(k), ~16'(k));
      repeat (3) @(posedge clk_i);
      if (k == 3) rd(8'h19, 8'h0F);
      if (k == 6) rd(8'h18, 8'h80);
      if (k == 6) `CHK(fifo_warn_o, 1'b1)
      if (k == 7) `CHK(in_ready_o, 1'b0)
    end
    for (int k = 0; k < 8; k++) pop_chk(16'(k), ~16'(k));
    tick;
    `CHK(sample_valid_o, 1'b0)
    `CHK(in_ready_o, 1'b1)
    // serial level reset waits for the read pointer wrap
    wr(8'h17, 8'h05);
    wr(8'h18, 8'h02);
    rd(8'h18, 8'h02);
    spin(8);
    rd(8'h18, 8'h06);
    rd(8'h19, 8'h1F);
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h00);
    // fifo rate mode: absolute load, sync clears read pointer
    wr(8'h17, 8'h02);
    wr(8'h10, 8'h80);
    @(posedge clk_i);
    port_mode_i <= DIP_WORD;
    src.strobe(2);
    repeat (2) @(posedge clk_i);
    rd(8'h19, 8'h03);
    tick;
    rd(8'h19, 8'h01);
    `CHK(fifo_warn_o, 1'b1)
    @(posedge clk_i);
    sync_pos_i <= 1'b1;
    @(posedge clk_i);
    sync_pos_i <= 1'b0;
    rd(8'h19, 8'h03);
    // falling-edge sync selected: only that input clears now
    wr(8'h10, 8'h88);
    tick;
    @(posedge clk_i);
    sync_pos_i <= 1'b1;
    @(posedge clk_i);
    sync_pos_i <= 1'b0;
    rd(8'h19, 8'h01);
    @(posedge clk_i);
    sync_neg_i <= 1'b1;
    @(posedge clk_i);
    sync_neg_i <= 1'b0;
    rd(8'h19, 8'h03);
    // data rate mode: frame reset stays pending until the wrap
    wr(8'h17, 8'h06);
    wr(8'h10, 8'hC0);
    src.strobe(2);
    repeat (2) @(posedge clk_i);
    rd(8'h19, 8'h07);
    @(posedge clk_i);
    port_mode_i <= DIP_DUAL_WORD;
    spin(8);
    rd(8'h19, 8'h3F);
    // clock enable low: a tick must neither pop nor move the read pointer
    @(posedge clk_i);
    ce_i <= 1'b0;
    tick;
    `CHK(sample_valid_o, 1'b0)
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(8'h19, 8'h3F);
    close_out;
  end
endmodule
